// *** core/kaam_pkg.sv ***
// Purpose: constants, types and helpers of the keypad auto-adjust menu
// Assumes: one clock, key inputs are one-cycle press pulses
// Notes: page number is two decimal digits, tens and ones
//
// How it works
// - Mode key from outside the menu shows the menu code.
// - Page 00 picks notch tuning, page 01 vibration suppressor tuning.
// - Page 02 picks command offset, page 03 torque addition offset.
// - Entry shows a page; 00 after power-up, else the last page.
// - Cursor key moves the blinking digit between tens and ones.
// - Up increments the blinking digit, down decrements it.
// - Write on pages 00..03 shows the confirm prompt and waits.
// - Up at the confirm prompt accepts and goes to readiness check.
// - Down at the confirm prompt cancels back to page selection.
// - Executable function shows the ready prompt, awaits write or mode.
// - Not executable shows not-ready; mode returns to page selection.
// - Mode at ready cancels: tuning to finish, offset to page select.
// - Write at ready starts the function; tuning shows running display.
// - Completion shows end, or error when the function fails.
// - Mode after completion: tuning back to ready, offset to pages.
// - Mode while tuning runs aborts it and goes to finish.
// - Finish state shows the finish prompt, ending tuning.
// - Speed-torque switching control mode makes functions unavailable.
// - Test-run pages 00..04: jog, alarm reset, save, enc clr, hist clr.

package kaam_pkg;

  localparam int CLK_NS = 4;
  localparam int CODE_DWELL_NS = 1000;
  localparam int CODE_DWELL_CYC = (CODE_DWELL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] DWELL_LAST = 8'(CODE_DWELL_CYC - 1);
  localparam logic [7:0] DWELL_ZERO = 8'h00;

  localparam logic [3:0] DIG_MIN = 4'h0;
  localparam logic [3:0] DIG_MAX = 4'h9;
  localparam logic [3:0] LAST_PAGE = 4'h3;
  localparam logic [3:0] TR_LAST_PAGE = 4'h4;

  localparam logic [1:0] FN_NOTCH = 2'h0;
  localparam logic [1:0] FN_VIBR = 2'h1;
  localparam logic [1:0] FN_OFS_CMD = 2'h2;
  localparam logic [1:0] FN_OFS_TADD = 2'h3;

  // Gray codes along idle, code, page, confirm, check, ready, run, done
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CODE = 4'h1, S_PSEL = 4'h3, S_CONF = 4'h2,
    S_CHK = 4'h6, S_RDY = 4'h7, S_RUN = 4'h5, S_DONE = 4'h4,
    S_NRDY = 4'hC, S_FIN = 4'hD
  } kaam_state_t;

  typedef enum logic [3:0] {
    DC_BLANK = 4'h0, DC_MENU = 4'h1, DC_PAGE = 4'h2, DC_NODATA = 4'h3,
    DC_CONFIRM = 4'h4, DC_READY = 4'h5, DC_NOTRDY = 4'h6,
    DC_RUNNING = 4'h7, DC_BUSY = 4'h8, DC_END = 4'h9, DC_ERR = 4'hA,
    DC_FINISH = 4'hB
  } kaam_disp_t;

  typedef enum logic [2:0] {
    TR_NONE = 3'h0, TR_JOG = 3'h1, TR_ALM_RST = 3'h2,
    TR_SAVE_TUNE = 3'h3, TR_ENC_CLR = 3'h4, TR_HIST_CLR = 3'h5
  } kaam_trun_t;

  function automatic logic [3:0] dig_inc(input logic [3:0] d);
    return (d >= DIG_MAX) ? DIG_MIN : 4'(d + 4'h1);
  endfunction : dig_inc

  function automatic logic [3:0] dig_dec(input logic [3:0] d);
    return (d == DIG_MIN || d > DIG_MAX) ? DIG_MAX : 4'(d - 4'h1);
  endfunction : dig_dec

  function automatic logic is_tuning(input logic [1:0] fn);
    return (fn == FN_NOTCH) || (fn == FN_VIBR);
  endfunction : is_tuning

  function automatic kaam_trun_t trun_map(input logic [3:0] tens,
                                          input logic [3:0] ones);
    if (tens != DIG_MIN || ones > TR_LAST_PAGE) begin
      return TR_NONE;
    end
    return kaam_trun_t'(3'(ones) + 3'h1);
  endfunction : trun_map

endpackage : kaam_pkg

// *** core/kaam_page_edit.sv ***
// Purpose: two-digit page number editor with blinking digit cursor
// Assumes: keys are one-cycle pulses, en high only during page selection
// Notes: digits keep their value while not editing, so the page is remembered
`timescale 1ns/100ps
`default_nettype none

module kaam_page_edit
  import kaam_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Keys
  input wire logic en,
  input wire logic key_cursor,
  input wire logic key_up,
  input wire logic key_down,
  // Page digits
  output logic [3:0] tens_o,
  output logic [3:0] ones_o,
  output logic blink_tens_o
);

  logic [3:0] tens_ff;
  logic [3:0] ones_ff;
  logic blink_ff;

  wire logic [3:0] cur_dig = blink_ff ? tens_ff : ones_ff;
  wire logic [3:0] new_dig = key_up ? dig_inc(cur_dig) : dig_dec(cur_dig);
  wire logic step = en && (key_up || key_down);
  wire logic [3:0] nxt_tens = (step && blink_ff) ? new_dig : tens_ff;
  wire logic [3:0] nxt_ones = (step && !blink_ff) ? new_dig : ones_ff;
  wire logic nxt_blink = (en && key_cursor) ? !blink_ff : blink_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tens_ff <= DIG_MIN;
      ones_ff <= DIG_MIN;
      blink_ff <= 1'b0;
    end else begin
      tens_ff <= nxt_tens;
      ones_ff <= nxt_ones;
      blink_ff <= nxt_blink;
    end
  end

  assign tens_o = tens_ff;
  assign ones_o = ones_ff;
  assign blink_tens_o = blink_ff;

  digit_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    en && key_up && !blink_ff && ones_ff == DIG_MAX |=> ones_ff == DIG_MIN)
    else $error("ones digit did not wrap to zero");

endmodule : kaam_page_edit

`default_nettype wire

// *** core/kaam_disp.sv ***
// Purpose: registered seven-segment display code for the menu
// Assumes: state and flags come from the menu controller
// Notes: the code appears one clock after the state that selects it
`timescale 1ns/100ps
`default_nettype none

module kaam_disp
  import kaam_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Menu status
  input wire kaam_state_t st,
  input wire logic tune,
  input wire logic err,
  input wire logic page_ok,
  // Display
  output kaam_disp_t disp_code_o
);

  kaam_disp_t code_ff;
  kaam_disp_t nxt_code;

  always_comb begin
    case (st)
      S_CODE: nxt_code = DC_MENU;
      S_PSEL: nxt_code = page_ok ? DC_PAGE : DC_NODATA;
      S_CONF: nxt_code = DC_CONFIRM;
      S_RDY: nxt_code = DC_READY;
      S_NRDY: nxt_code = DC_NOTRDY;
      S_RUN: nxt_code = tune ? DC_RUNNING : DC_BUSY;
      S_DONE: nxt_code = err ? DC_ERR : DC_END;
      S_FIN: nxt_code = DC_FINISH;
      default: nxt_code = DC_BLANK;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      code_ff <= DC_BLANK;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign disp_code_o = code_ff;

  finish_show_a: assert property (@(posedge mclk) disable iff (rst)
    st == S_FIN |=> disp_code_o == DC_FINISH)
    else $error("finish prompt not shown");

endmodule : kaam_disp

`default_nettype wire

// *** core/kaam_menu_top.sv ***
// Purpose: auto-adjust menu controller of the front-panel keypad
// Assumes: key inputs are one-cycle pulses synchronous to mclk
// Notes: mode key beats write, up beats down; up and down still step the page digit with mode or write
`timescale 1ns/100ps
`default_nettype none

module kaam_menu_top
  import kaam_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Keypad
  input wire logic key_mode,
  input wire logic key_cursor,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_wr,
  // Amplifier status
  input wire logic fn_ready,
  input wire logic ctrl_vt_switch,
  input wire logic fn_done,
  input wire logic fn_fail,
  // Function control
  output logic fn_start,
  output logic fn_abort,
  output logic [1:0] fn_sel,
  // Display
  output kaam_disp_t disp_code,
  output logic [3:0] disp_tens,
  output logic [3:0] disp_ones,
  output logic blink_tens,
  output logic menu_active,
  // Test-run page map
  output kaam_trun_t trun_func
);

  kaam_state_t st_ff;
  kaam_state_t nxt_st;
  logic [7:0] dwell_ff;
  logic [1:0] sel_ff;
  logic err_ff;
  logic start_ff;
  logic abort_ff;
  kaam_trun_t trun_ff;
  logic [3:0] tens;
  logic [3:0] ones;

  // Decoded conditions
  wire logic in_psel = (st_ff == S_PSEL);
  wire logic page_ok = (tens == DIG_MIN) && (ones <= LAST_PAGE);
  wire logic [1:0] page_fn = ones[1:0];
  wire logic tune = is_tuning(sel_ff);
  wire logic fn_ok = fn_ready && !ctrl_vt_switch;
  wire logic dwell_end = (dwell_ff == DWELL_LAST);
  wire logic take_wr = key_wr && !key_mode;
  wire logic take_up = key_up && !key_mode && !key_wr;
  wire logic take_down = key_down && !key_mode && !key_wr && !key_up;

  kaam_page_edit u_page (
    .mclk(mclk),
    .rst(rst),
    .en(in_psel),
    .key_cursor(key_cursor),
    .key_up(key_up),
    .key_down(key_down),
    .tens_o(tens),
    .ones_o(ones),
    .blink_tens_o(blink_tens)
  );

  kaam_disp u_disp (
    .mclk(mclk),
    .rst(rst),
    .st(st_ff),
    .tune(tune),
    .err(err_ff),
    .page_ok(page_ok),
    .disp_code_o(disp_code)
  );

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: begin
        if (key_mode) begin
          nxt_st = S_CODE;
        end
      end
      S_CODE: begin
        if (dwell_end) begin
          nxt_st = S_PSEL;
        end
      end
      S_PSEL: begin
        if (key_mode) begin
          nxt_st = S_IDLE;
        end else if (key_wr && page_ok) begin
          nxt_st = S_CONF;
        end
      end
      S_CONF: begin
        if (key_up) begin
          nxt_st = S_CHK;
        end else if (key_down) begin
          nxt_st = S_PSEL;
        end
      end
      S_CHK: begin
        nxt_st = fn_ok ? S_RDY : S_NRDY;
      end
      S_NRDY: begin
        if (key_mode) begin
          nxt_st = S_PSEL;
        end
      end
      S_RDY: begin
        if (key_mode) begin
          nxt_st = tune ? S_FIN : S_PSEL;
        end else if (key_wr) begin
          nxt_st = S_RUN;
        end
      end
      S_RUN: begin
        if (key_mode && tune) begin
          nxt_st = S_FIN;
        end else if (fn_done) begin
          nxt_st = S_DONE;
        end
      end
      S_DONE: begin
        if (key_mode) begin
          nxt_st = tune ? S_RDY : S_PSEL;
        end
      end
      S_FIN: begin
        if (key_mode) begin
          nxt_st = S_PSEL;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  // Register next values
  wire logic [7:0] nxt_dwell =
    (st_ff == S_CODE && !dwell_end) ? 8'(dwell_ff + 8'h01) : DWELL_ZERO;
  wire logic [1:0] nxt_sel =
    (in_psel && take_wr && page_ok) ? page_fn : sel_ff;
  wire logic nxt_err = (st_ff == S_RUN && fn_done) ? fn_fail : err_ff;
  wire logic nxt_start = (st_ff == S_RDY) && take_wr;
  wire logic nxt_abort = (st_ff == S_RUN) && key_mode && tune;
  wire kaam_trun_t nxt_trun = trun_map(tens, ones);

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= S_IDLE;
      dwell_ff <= DWELL_ZERO;
      sel_ff <= FN_NOTCH;
      err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      dwell_ff <= nxt_dwell;
      sel_ff <= nxt_sel;
      err_ff <= nxt_err;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      trun_ff <= TR_NONE;
    end else begin
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
      trun_ff <= nxt_trun;
    end
  end

  assign fn_start = start_ff;
  assign fn_abort = abort_ff;
  assign fn_sel = sel_ff;
  assign disp_tens = tens;
  assign disp_ones = ones;
  assign menu_active = (st_ff != S_IDLE);
  assign trun_func = trun_ff;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  menu_code_a: assert property (
    st_ff == S_IDLE && key_mode |-> ##2 disp_code == DC_MENU)
    else $error("menu code not shown after mode key");

  page_entry_a: assert property (
    st_ff == S_CODE && dwell_end |=> in_psel ##1 disp_code != DC_MENU)
    else $error("page not shown after menu code");

  confirm_show_a: assert property (
    in_psel && take_wr && page_ok |=> st_ff == S_CONF
      ##1 disp_code == DC_CONFIRM)
    else $error("confirm prompt missing after write");

  unalloc_page_a: assert property (
    in_psel && take_wr && !page_ok |=> in_psel && !fn_start)
    else $error("unallocated page left page selection");

  confirm_yes_a: assert property (
    st_ff == S_CONF && key_up |=> st_ff == S_CHK)
    else $error("up key at confirm did not go to check");

  confirm_no_a: assert property (
    st_ff == S_CONF && take_down |=> in_psel)
    else $error("down key at confirm did not cancel");

  ready_check_a: assert property (
    st_ff == S_CHK && fn_ok |=> st_ff == S_RDY ##1 disp_code == DC_READY)
    else $error("ready prompt missing");

  vt_block_a: assert property (
    st_ff == S_CHK && ctrl_vt_switch |=> st_ff == S_NRDY)
    else $error("switching control mode did not block execution");

  notrdy_exit_a: assert property (
    st_ff == S_NRDY && key_mode |=> in_psel)
    else $error("mode key at not-ready did not return");

  ready_cancel_a: assert property (
    st_ff == S_RDY && key_mode |=> (tune ? st_ff == S_FIN : in_psel))
    else $error("cancel at ready went to wrong state");

  start_pulse_a: assert property (
    st_ff == S_RDY && take_wr |=> fn_start && st_ff == S_RUN
      ##1 !fn_start)
    else $error("start is not a single pulse into run");

  run_show_a: assert property (
    st_ff == S_RUN && tune && !key_mode && !fn_done
      |=> disp_code == DC_RUNNING)
    else $error("running display missing during tuning");

  done_code_a: assert property (
    st_ff == S_RUN && !(key_mode && tune) && fn_done
      |-> ##2 disp_code == ($past(fn_fail, 2) ? DC_ERR : DC_END))
    else $error("completion display does not match result");

  done_return_a: assert property (
    st_ff == S_DONE && key_mode
      |=> st_ff == ($past(tune) ? S_RDY : S_PSEL))
    else $error("mode key after completion went wrong way");

  tune_abort_a: assert property (
    st_ff == S_RUN && tune && key_mode |=> fn_abort && st_ff == S_FIN)
    else $error("tuning not aborted by mode key");

  trun_map_a: assert property (
    tens == DIG_MIN && ones == TR_LAST_PAGE |=> trun_func == TR_HIST_CLR)
    else $error("test-run page four not history clear");

  code_hold_a: assert property (
    st_ff == S_CODE && !dwell_end |=> st_ff == S_CODE)
    else $error("menu code left before its dwell ended");

  page_hold_a: assert property (
    in_psel && !key_mode && !key_wr |=> in_psel)
    else $error("page selection left without a key");

  sel_latch_a: assert property (
    in_psel && take_wr && page_ok |=> fn_sel == $past(page_fn))
    else $error("selected function does not follow the page");

  check_once_a: assert property (
    st_ff == S_CHK |=> st_ff == S_RDY || st_ff == S_NRDY)
    else $error("readiness check did not resolve in one cycle");

  ready_hold_a: assert property (
    st_ff == S_RDY && !key_mode && !key_wr |=> st_ff == S_RDY)
    else $error("ready prompt left without a key");

  notrdy_show_a: assert property (
    st_ff == S_NRDY |=> disp_code == DC_NOTRDY)
    else $error("not-ready prompt missing");

  busy_show_a: assert property (
    st_ff == S_RUN && !tune |=> disp_code == DC_BUSY)
    else $error("offset run shows wrong display");

  run_done_a: assert property (
    st_ff == S_RUN && fn_done && !(key_mode && tune) |=> st_ff == S_DONE)
    else $error("completion not taken from run");

  offset_run_a: assert property (
    st_ff == S_RUN && !tune |=> !fn_abort)
    else $error("offset function was aborted");

  finish_exit_a: assert property (
    st_ff == S_FIN && key_mode |=> in_psel)
    else $error("mode key at finish did not return to pages");

  trun_jog_a: assert property (
    tens == DIG_MIN && ones == DIG_MIN |=> trun_func == TR_JOG)
    else $error("test-run page zero not jog");

endmodule : kaam_menu_top

`default_nettype wire

// *** tb/kaam_amp_model.sv ***
// Purpose: amplifier side model, answers a start with done after a delay
// Assumes: fn_start and fn_abort are one-cycle pulses
// Notes: fn_fail toggles outside done, it means nothing there
`timescale 1ns/100ps
`default_nettype none

module kaam_amp_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Function control
  input wire logic fn_start,
  input wire logic fn_abort,
  // Behaviour set by the bench
  input wire logic fail_req,
  input wire logic [7:0] lat,
  // Status
  output logic fn_done,
  output logic fn_fail
);
  logic busy_ff;
  logic done_ff;
  logic junk_ff;
  logic [7:0] cnt_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      junk_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else begin
      junk_ff <= ~junk_ff;
      done_ff <= 1'b0;
      if (fn_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat;
      end else if (fn_abort) begin
        busy_ff <= 1'b0;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  assign fn_done = done_ff;
  assign fn_fail = done_ff ? fail_req : junk_ff;
endmodule : kaam_amp_model
`default_nettype wire

// *** tb/kaam_menu_top_test.sv ***
// Purpose: self-checking bench of the auto-adjust menu
// Assumes: keys are one-cycle pulses given at the rising edge
// Notes: fn_done and fn_fail come from kaam_amp_model, fn_ready and ctrl_vt_switch from the bench
`timescale 1ns/100ps
`default_nettype none

module kaam_menu_top_test
  import kaam_pkg::*;
;
  localparam int K_MODE = 0;
  localparam int K_CUR = 1;
  localparam int K_UP = 2;
  localparam int K_DN = 3;
  localparam int K_WR = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic key_mode, key_cursor, key_up, key_down, key_wr;
  logic fn_ready, ctrl_vt_switch, fail_req, fn_done, fn_fail;
  logic fn_start, fn_abort, blink_tens, menu_active;
  logic [7:0] lat;
  logic [1:0] fn_sel;
  logic [3:0] disp_tens, disp_ones;
  kaam_disp_t disp_code;
  kaam_trun_t trun_func;
  int error_cnt = 0;
  int compares = 0;

  always #2 mclk = ~mclk;

  kaam_menu_top DUT (.mclk(mclk), .rst(rst), .key_mode(key_mode),
    .key_cursor(key_cursor), .key_up(key_up), .key_down(key_down),
    .key_wr(key_wr), .fn_ready(fn_ready), .ctrl_vt_switch(ctrl_vt_switch),
    .fn_done(fn_done), .fn_fail(fn_fail), .fn_start(fn_start),
    .fn_abort(fn_abort), .fn_sel(fn_sel), .disp_code(disp_code),
    .disp_tens(disp_tens), .disp_ones(disp_ones), .blink_tens(blink_tens),
    .menu_active(menu_active), .trun_func(trun_func));

  kaam_amp_model amp (.mclk(mclk), .rst(rst), .fn_start(fn_start),
    .fn_abort(fn_abort), .fail_req(fail_req), .lat(lat),
    .fn_done(fn_done), .fn_fail(fn_fail));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic press(input int k);
    @(posedge mclk);
    case (k)
      K_MODE: key_mode <= 1'b1;
      K_CUR: key_cursor <= 1'b1;
      K_UP: key_up <= 1'b1;
      K_DN: key_down <= 1'b1;
      default: key_wr <= 1'b1;
    endcase
    @(posedge mclk);
    {key_mode, key_cursor, key_up, key_down, key_wr} <= 5'h00;
    #1;
  endtask : press

  task automatic step(input int k, input int n, input kaam_disp_t exp);
    press(k);
    repeat (n) @(posedge mclk);
    #1;
    chk(disp_code, exp);
  endtask : step

  task automatic wait_disp(input kaam_disp_t exp);
    int i;
    for (i = 0; i < 300 && disp_code !== exp; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(disp_code, exp);
  endtask : wait_disp

  task automatic go_ready(input kaam_disp_t exp);
    step(K_WR, 1, DC_CONFIRM);
    step(K_UP, 2, exp);
  endtask : go_ready

  task automatic t_enter(input logic [7:0] pg);
    step(K_MODE, 1, DC_MENU);
    repeat (CODE_DWELL_CYC - 1) @(posedge mclk);
    #1;
    chk(disp_code, DC_MENU);
    chk(menu_active, 1'b1);
    @(posedge mclk);
    #1;
    chk(disp_code, DC_PAGE);
    chk({disp_tens, disp_ones}, pg);
    $display("test enter done");
  endtask : t_enter

  task automatic t_edit;
    int i;
    press(K_UP);
    chk(disp_ones, 4'h1);
    press(K_DN);
    press(K_DN);
    chk(disp_ones, 4'h9);
    press(K_UP);
    chk(disp_ones, 4'h0);
    press(K_CUR);
    chk(blink_tens, 1'b1);
    press(K_DN);
    chk({disp_tens, disp_ones}, 8'h90);
    step(K_WR, 1, DC_NODATA);
    press(K_UP);
    chk(disp_tens, 4'h0);
    press(K_CUR);
    chk(blink_tens, 1'b0);
    for (i = 0; i < 6; i++) begin
      @(posedge mclk);
      #1;
      chk(trun_func, (i < 5) ? 8'(i + 1) : 8'h00);
      press(K_UP);
    end
    for (i = 0; i < 6; i++) begin
      press(K_DN);
    end
    step(K_WR, 1, DC_CONFIRM);
    step(K_DN, 1, DC_PAGE);
    chk({disp_tens, disp_ones}, 8'h00);
    $display("test edit done");
  endtask : t_edit

  task automatic t_tune;
    go_ready(DC_READY);
    press(K_WR);
    chk(fn_start, 1'b1);
    chk(fn_sel, 2'h0);
    @(posedge mclk);
    #1;
    chk(fn_start, 1'b0);
    chk(disp_code, DC_RUNNING);
    wait_disp(DC_END);
    step(K_MODE, 1, DC_READY);
    step(K_MODE, 1, DC_FINISH);
    step(K_MODE, 1, DC_PAGE);
    press(K_UP);
    go_ready(DC_READY);
    @(posedge mclk);
    lat <= 8'hC8;
    press(K_WR);
    chk(fn_sel, 2'h1);
    press(K_MODE);
    chk(fn_abort, 1'b1);
    @(posedge mclk);
    #1;
    chk(disp_code, DC_FINISH);
    step(K_MODE, 1, DC_PAGE);
    $display("test tune done");
  endtask : t_tune

  task automatic t_offset;
    press(K_UP);
    go_ready(DC_READY);
    step(K_MODE, 1, DC_PAGE);
    go_ready(DC_READY);
    @(posedge mclk);
    fail_req <= 1'b1;
    lat <= 8'h08;
    press(K_WR);
    chk(fn_sel, 2'h2);
    @(posedge mclk);
    #1;
    chk(disp_code, DC_BUSY);
    wait_disp(DC_ERR);
    step(K_MODE, 1, DC_PAGE);
    $display("test offset done");
  endtask : t_offset

  task automatic t_notready;
    press(K_UP);
    @(posedge mclk);
    ctrl_vt_switch <= 1'b1;
    go_ready(DC_NOTRDY);
    chk(fn_sel, 2'h3);
    step(K_MODE, 1, DC_PAGE);
    @(posedge mclk);
    ctrl_vt_switch <= 1'b0;
    fn_ready <= 1'b0;
    go_ready(DC_NOTRDY);
    step(K_MODE, 1, DC_PAGE);
    step(K_MODE, 1, DC_BLANK);
    chk(menu_active, 1'b0);
    $display("test not ready done");
  endtask : t_notready

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    {key_mode, key_cursor, key_up, key_down, key_wr} = 5'h00;
    fn_ready = 1'b1;
    ctrl_vt_switch = 1'b0;
    fail_req = 1'b0;
    lat = 8'h10;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(disp_code, DC_BLANK);
    chk({disp_tens, disp_ones}, 8'h00);
    t_enter(8'h00);
    t_edit;
    t_tune;
    t_offset;
    t_notready;
    t_enter(8'h03);
    finish_test;
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test;
  end
endmodule : kaam_menu_top_test
`default_nettype wire
